// ### common/sys_port_pkg.sv
// Purpose: shared constants and types for the system-side port signal block
// Assumes: core_clk at 100 MHz samples both link clocks as ordinary inputs
// Notes: bus mode and width encodings are local choices
package sys_port_pkg;
  typedef enum logic [1:0] {
    MODE_CELL_L2 = 2'h0,
    MODE_CELL_L3 = 2'h1,
    MODE_PKT_L3 = 2'h3,
    MODE_PKT_L2 = 2'h2
  } bus_mode_t;
  typedef enum logic [1:0] {
    WIDTH_8 = 2'h0,
    WIDTH_16 = 2'h1,
    WIDTH_32 = 2'h2
  } bus_width_t;
  localparam logic [1:0] MOD_ALL = 2'h0;
  localparam logic [1:0] MOD_TOP3 = 2'h1;
  localparam logic [1:0] MOD_TOP2 = 2'h2;
  localparam logic [1:0] MOD_TOP1 = 2'h3;
  localparam int PORT_ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int SYNC_STAGES = 2;
  localparam logic [4:0] ADDR_RESET = 5'h1F;
  localparam int CORE_CLK_MHZ = 100;
  localparam int RX_CLK_MAX_L3_MHZ = 66;
  localparam int RX_CLK_MAX_L2_MHZ = 52;
  // least core cycles between two link edges at the fastest legal link clock
  localparam int RX_MIN_PERIOD_CYC_L3 = CORE_CLK_MHZ / RX_CLK_MAX_L3_MHZ;
  localparam int RX_MIN_PERIOD_CYC_L2 = CORE_CLK_MHZ / RX_CLK_MAX_L2_MHZ;
endpackage

// ### common/sync_bus_if.sv
// Purpose: carries a raw bus into the synchroniser and the clean copy out
// Assumes: one clock domain on the synchronised side
// Notes: width set by parameter
interface sync_bus_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport src (output raw, input clean);
  modport sync (input raw, output clean);
endinterface

// ### design/sync2.sv
// Purpose: two-flop synchroniser for a bus of pins
// Assumes: synchronous active-low reset
// Notes: first stage is read by the second stage only
module sync2
  import sys_port_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  sync_bus_if.sync bus
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] clean_q;
  logic [W-1:0] clean_d;

  always_comb
  begin
    meta_d = bus.raw;
    clean_d = meta_q;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      clean_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      clean_q <= clean_d;
    end
  end

  assign bus.clean = clean_q;
endmodule

// ### design/sys_port_signals.sv
// Purpose: transmit space flag, packet tail/abort decode, port addressing
// Assumes: link clocks and link inputs are sampled by core_clk via two flops
// Notes: one core cycle of edge-detect latency after synchronising
//
// How it works
// - packet modes: flag high when selected port has room
// - packet L2 drives flag only while selected
// - cell L3 holds low; packet L3 always drives
// - cell L2 keeps flag tri-stated always
// - last flag sampled on tx edge, packet only
// - strobe cycle data names the target port
// - strobe meaningful only with enable deasserted
// - strobe ignored except in packet L3
// - modulus codes the valid byte lanes
// - modulus used only with last flag
// - modulus ignored at 8/16 bit, cell modes
// - error flag aborts current packet
// - error valid only with last flag
// - rx port select sampled on rx edge
// - rx port select ignored in packet L3
module sys_port_signals
  import sys_port_pkg::*;
#(
  parameter int NUM_PORTS = 4
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire bus_mode_t bus_mode,
  input wire bus_width_t bus_width,
  input wire logic datapath_reset,
  input wire logic tx_system_clock,
  input wire logic tx_enable_n,
  input wire logic tx_packet_last_flag,
  input wire logic tx_transfer_address_strobe,
  input wire logic [1:0] tx_byte_modulus,
  input wire logic tx_packet_error_flag,
  input wire logic tx_first_transfer_flag,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic [PORT_ADDR_W-1:0] tx_port_select,
  input wire logic [NUM_PORTS-1:0] port_has_room,
  input wire logic rx_system_clock,
  input wire logic [PORT_ADDR_W-1:0] rx_port_select_bus,
  output logic selected_port_space_flag_o,
  output logic selected_port_space_flag_oe,
  output logic [PORT_ADDR_W-1:0] tx_target_port,
  output logic tx_target_valid,
  output logic tx_word_strobe,
  output logic [3:0] tx_byte_valid,
  output logic tx_packet_start,
  output logic tx_packet_end,
  output logic tx_packet_abort,
  output logic [PORT_ADDR_W-1:0] rx_transfer_port,
  output logic [PORT_ADDR_W-1:0] rx_polled_port,
  output logic rx_addr_strobe
);
  localparam int TXW = 8 + DATA_W + PORT_ADDR_W + NUM_PORTS;

  sync_bus_if #(.W(TXW)) tx_sync ();
  sync_bus_if #(.W(1 + PORT_ADDR_W)) rx_sync ();

  assign tx_sync.raw = {tx_system_clock, tx_enable_n, tx_packet_last_flag,
                        tx_transfer_address_strobe, tx_byte_modulus,
                        tx_packet_error_flag, tx_first_transfer_flag, tx_data, tx_port_select,
                        port_has_room};
  assign rx_sync.raw = {rx_system_clock, rx_port_select_bus};

  // bundling keeps data and clock aligned through equal flop depth
  sync2 #(.W(TXW)) u_tx_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .bus(tx_sync)
  );
  sync2 #(.W(1 + PORT_ADDR_W)) u_rx_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .bus(rx_sync)
  );

  logic s_tclk;
  logic s_ten_n;
  logic s_last;
  logic s_strobe;
  logic [1:0] s_mod;
  logic s_err;
  logic s_first;
  logic [DATA_W-1:0] s_data;
  logic [PORT_ADDR_W-1:0] s_sel;
  logic [NUM_PORTS-1:0] s_room;
  logic s_rclk;
  logic [PORT_ADDR_W-1:0] s_radr;

  assign {s_tclk, s_ten_n, s_last, s_strobe, s_mod, s_err, s_first, s_data, s_sel, s_room} =
    tx_sync.clean;
  assign {s_rclk, s_radr} = rx_sync.clean;

  logic tclk_prev_q;
  logic tclk_prev_d;
  logic rclk_prev_q;
  logic rclk_prev_d;
  logic tx_edge;
  logic rx_edge;
  logic pkt_mode;
  logic pkt_l3;
  logic port_selected;
  logic port_room;

  assign tx_edge = s_tclk & ~tclk_prev_q;
  assign rx_edge = s_rclk & ~rclk_prev_q;
  assign pkt_mode = (bus_mode == MODE_PKT_L2) || (bus_mode == MODE_PKT_L3);
  assign pkt_l3 = (bus_mode == MODE_PKT_L3);
  // any select of NUM_PORTS or above means no port addressed
  assign port_selected = (s_sel < PORT_ADDR_W'(NUM_PORTS));
  assign port_room = port_selected && s_room[s_sel[1:0]];

  // space flag state
  logic flag_q;
  logic flag_d;
  logic flag_oe_q;
  logic flag_oe_d;

  always_comb
  begin
    flag_d = flag_q;
    flag_oe_d = flag_oe_q;
    if (datapath_reset)
    begin
      flag_d = 1'b0;
      flag_oe_d = (bus_mode == MODE_PKT_L3) || (bus_mode == MODE_CELL_L3);
    end
    else if (tx_edge)
    begin
      case (bus_mode)
        MODE_CELL_L2:
        begin
          flag_d = 1'b0;
          flag_oe_d = 1'b0;
        end
        MODE_CELL_L3:
        begin
          flag_d = 1'b0;
          flag_oe_d = 1'b1;
        end
        MODE_PKT_L3:
        begin
          flag_d = port_room;
          flag_oe_d = 1'b1;
        end
        default:
        begin
          flag_d = port_room;
          flag_oe_d = port_selected && !s_ten_n;
        end
      endcase
    end
    // level 3 drives from reset release on, not from the first link edge
    if (bus_mode == MODE_CELL_L3 || bus_mode == MODE_PKT_L3)
    begin
      flag_oe_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      flag_q <= 1'b0;
      flag_oe_q <= 1'b0;
      tclk_prev_q <= 1'b0;
      rclk_prev_q <= 1'b0;
    end
    else
    begin
      flag_q <= flag_d;
      flag_oe_q <= flag_oe_d;
      tclk_prev_q <= tclk_prev_d;
      rclk_prev_q <= rclk_prev_d;
    end
  end

  always_comb
  begin
    tclk_prev_d = s_tclk;
    rclk_prev_d = s_rclk;
  end

  // in packet L2, tri-state also follows enable, port select and datapath reset without waiting for an edge
  assign selected_port_space_flag_o = flag_q;
  assign selected_port_space_flag_oe = flag_oe_q && !(bus_mode == MODE_PKT_L2 &&
    (s_ten_n || !port_selected || datapath_reset));

  // transmit packet decode
  logic [PORT_ADDR_W-1:0] target_q;
  logic [PORT_ADDR_W-1:0] target_d;
  logic target_valid_q;
  logic target_valid_d;
  logic word_q;
  logic word_d;
  logic [3:0] bytes_q;
  logic [3:0] bytes_d;
  logic start_q;
  logic start_d;
  logic end_q;
  logic end_d;
  logic abort_q;
  logic abort_d;

  always_comb
  begin
    target_d = target_q;
    target_valid_d = target_valid_q;
    word_d = 1'b0;
    bytes_d = bytes_q;
    start_d = 1'b0;
    end_d = 1'b0;
    abort_d = 1'b0;
    if (datapath_reset)
    begin
      target_valid_d = 1'b0;
    end
    else if (tx_edge)
    begin
      if (pkt_l3 && s_ten_n && s_strobe)
      begin
        target_d = s_data[PORT_ADDR_W-1:0];
        target_valid_d = 1'b1;
      end
      else if (!s_ten_n)
      begin
        word_d = 1'b1;
        start_d = s_first;
        bytes_d = 4'hF;
        if (pkt_mode && s_last)
        begin
          end_d = 1'b1;
          abort_d = s_err;
          if (bus_width == WIDTH_32)
          begin
            case (s_mod)
              MOD_ALL: bytes_d = 4'hF;
              MOD_TOP3: bytes_d = 4'hE;
              MOD_TOP2: bytes_d = 4'hC;
              default: bytes_d = 4'h8;
            endcase
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      target_q <= '0;
      target_valid_q <= 1'b0;
      word_q <= 1'b0;
      bytes_q <= 4'hF;
      start_q <= 1'b0;
      end_q <= 1'b0;
      abort_q <= 1'b0;
    end
    else
    begin
      target_q <= target_d;
      target_valid_q <= target_valid_d;
      word_q <= word_d;
      bytes_q <= bytes_d;
      start_q <= start_d;
      end_q <= end_d;
      abort_q <= abort_d;
    end
  end

  assign tx_target_port = target_q;
  assign tx_target_valid = target_valid_q;
  assign tx_word_strobe = word_q;
  assign tx_byte_valid = bytes_q;
  assign tx_packet_start = start_q;
  assign tx_packet_end = end_q;
  assign tx_packet_abort = abort_q;

  // receive port select, held at reset address in packet L3
  logic [PORT_ADDR_W-1:0] rx_port_q;
  logic [PORT_ADDR_W-1:0] rx_port_d;
  logic rx_stb_q;
  logic rx_stb_d;

  always_comb
  begin
    rx_port_d = rx_port_q;
    rx_stb_d = 1'b0;
    if (rx_edge && !pkt_l3)
    begin
      rx_port_d = s_radr;
      rx_stb_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rx_port_q <= ADDR_RESET;
      rx_stb_q <= 1'b0;
    end
    else
    begin
      rx_port_q <= rx_port_d;
      rx_stb_q <= rx_stb_d;
    end
  end

  assign rx_transfer_port = rx_port_q;
  assign rx_polled_port = rx_port_q;
  assign rx_addr_strobe = rx_stb_q;
endmodule

// ### tb/sys_port_signals_assertions.sv
// Purpose: port checker for sys_port_signals
// Assumes: bus mode and width change only while rst_n is low
// Notes: bound at the foot of this file
module sys_port_signals_assertions
  import sys_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire bus_mode_t bus_mode,
  input wire bus_width_t bus_width,
  input wire logic datapath_reset,
  input wire logic tx_enable_n,
  input wire logic [PORT_ADDR_W-1:0] rx_port_select_bus,
  input wire logic selected_port_space_flag_o,
  input wire logic selected_port_space_flag_oe,
  input wire logic tx_target_valid,
  input wire logic tx_word_strobe,
  input wire logic [3:0] tx_byte_valid,
  input wire logic tx_packet_end,
  input wire logic tx_packet_abort,
  input wire logic [PORT_ADDR_W-1:0] rx_transfer_port,
  input wire logic [PORT_ADDR_W-1:0] rx_polled_port,
  input wire logic rx_addr_strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_cell_l2_float: assert property (
    (bus_mode == MODE_CELL_L2)[*3] |-> !selected_port_space_flag_oe)
    else $error("flag driven in cell L2");
  a_cell_l3_low: assert property (
    (bus_mode == MODE_CELL_L3)[*3] |-> !selected_port_space_flag_o)
    else $error("flag high in cell L3");
  a_pkt_l3_drive: assert property (
    (bus_mode == MODE_PKT_L3)[*4] |-> selected_port_space_flag_oe)
    else $error("flag not driven in packet L3");
  a_pkt_l2_float: assert property ((bus_mode == MODE_PKT_L2 && (tx_enable_n || datapath_reset))[*4]
    |-> !selected_port_space_flag_oe)
    else $error("flag driven while released");
  a_rx_hold_l3: assert property (
    (bus_mode == MODE_PKT_L3)[*2] |-> $stable(rx_transfer_port))
    else $error("rx port moved in packet L3");
  a_rx_sample: assert property (rx_addr_strobe && bus_mode != MODE_PKT_L3
    |-> rx_polled_port == $past(rx_port_select_bus, 4))
    else $error("rx polled port wrong");
  a_word_pulse: assert property (tx_word_strobe |=> !tx_word_strobe)
    else $error("word strobe too long");
  a_end_pkt_only: assert property (tx_packet_end
    |-> tx_word_strobe && bus_mode inside {MODE_PKT_L2, MODE_PKT_L3})
    else $error("end outside packet mode");
  a_abort_at_end: assert property (tx_packet_abort |-> tx_packet_end)
    else $error("abort without end");
  a_lanes_full: assert property (tx_word_strobe && (!tx_packet_end || bus_width != WIDTH_32)
    |-> tx_byte_valid == 4'hF)
    else $error("partial lanes off last word");
  a_addr_l3_only: assert property ($rose(tx_target_valid) |-> bus_mode == MODE_PKT_L3)
    else $error("target outside packet L3");
  c_abort: cover property (tx_packet_abort);
  c_target: cover property ($rose(tx_target_valid));
  c_lane: cover property (tx_packet_end && tx_byte_valid == 4'h8);
endmodule
bind sys_port_signals sys_port_signals_assertions sys_port_signals_assertions_i (.*);

// ### tb/link_model.sv
// Purpose: link device model driving the transmit and receive pins
// Assumes: link clocks 80 ns period, far below the legal maximum
// Notes: clocks stand still low between words
module link_model (
  input wire logic core_clk,
  output logic tx_system_clock,
  output logic rx_system_clock,
  output logic tx_enable_n,
  output logic tx_first_transfer_flag,
  output logic tx_packet_last_flag,
  output logic tx_transfer_address_strobe,
  output logic tx_packet_error_flag,
  output logic [1:0] tx_byte_modulus,
  output logic [31:0] tx_data,
  output logic [4:0] rx_port_select_bus
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {tx_system_clock, rx_system_clock, tx_first_transfer_flag, tx_packet_last_flag} = '0;
    {tx_transfer_address_strobe, tx_packet_error_flag, tx_byte_modulus, tx_data} = '0;
    tx_enable_n = 1'b1;
    rx_port_select_bus = '0;
  end
  // one word on both links; pins settle half a period before the edge
  task automatic word(input logic en, s, e, x, r, input logic [1:0] m,
    input logic [31:0] d, input logic [4:0] a);
    @(negedge core_clk);
    tx_enable_n = en;
    tx_first_transfer_flag = s;
    tx_packet_last_flag = e;
    tx_transfer_address_strobe = x;
    tx_packet_error_flag = r;
    tx_byte_modulus = m;
    tx_data = d;
    rx_port_select_bus = a;
    #40 {tx_system_clock, rx_system_clock} = 2'b11;
    #40 {tx_system_clock, rx_system_clock} = 2'b00;
  endtask
endmodule

// ### tb/tb.sv
// Purpose: self-checking bench for sys_port_signals
// Assumes: each mode is entered through a reset
// Notes: word outputs captured at the strobe
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sys_port_pkg::*;
  logic core_clk = 0, rst_n = 0, datapath_reset = 0;
  bus_mode_t bus_mode = MODE_CELL_L2;
  bus_width_t bus_width = WIDTH_32;
  logic [4:0] tx_port_select = 1, rx_port_select_bus, tx_target_port, rx_transfer_port;
  logic [4:0] rx_polled_port;
  logic [3:0] port_has_room = 4'hF, tx_byte_valid;
  logic [31:0] tx_data;
  logic [1:0] tx_byte_modulus;
  logic tx_system_clock, tx_enable_n, tx_packet_last_flag, tx_transfer_address_strobe;
  logic tx_packet_error_flag, tx_first_transfer_flag, rx_system_clock, tx_target_valid;
  logic selected_port_space_flag_o, selected_port_space_flag_oe, tx_word_strobe;
  logic tx_packet_start, tx_packet_end, tx_packet_abort, rx_addr_strobe;
  logic [6:0] ev;
  logic [3:0] lanes [4] = '{4'hF, 4'hE, 4'hC, 4'h8};
  int num_errors = 0, compares = 0, cyc = 0;
  sys_port_signals sys_port_signals_i (.*);
  link_model link_model_i (.*);
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (tx_word_strobe)
      ev <= {tx_packet_start, tx_packet_abort, tx_packet_end, tx_byte_valid};
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic go(input bus_mode_t m, input bus_width_t w);
    @(negedge core_clk);
    rst_n = 0;
    bus_mode = m;
    bus_width = w;
    repeat (3) @(negedge core_clk);
    rst_n = 1;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic w(input logic en, s, e, x, r, input logic [1:0] m,
    input logic [31:0] d, input logic [4:0] a);
    ev = '0;
    link_model_i.word(en, s, e, x, r, m, d, a);
    repeat (6) @(negedge core_clk);
  endtask
  task automatic t_cell_l2();
    go(MODE_CELL_L2, WIDTH_32);
    w(0, 1, 1, 0, 1, 2'h3, 0, 5'h0A);
    chk(selected_port_space_flag_oe, 0);
    chk(ev, 7'h4F);
    chk(rx_transfer_port, 5'h0A);
    chk(rx_polled_port, 5'h0A);
    w(0, 0, 0, 0, 0, 0, 0, 5'h15);
    chk(rx_transfer_port, 5'h15);
  endtask
  task automatic t_pkt_l2();
    go(MODE_PKT_L2, WIDTH_32);
    w(0, 1, 0, 1, 0, 0, 5, 0);
    chk(selected_port_space_flag_oe, 1);
    chk(selected_port_space_flag_o, 1);
    chk(tx_target_valid, 0);
    port_has_room = 0;
    w(0, 0, 0, 0, 0, 0, 0, 0);
    chk(selected_port_space_flag_o, 0);
    for (int i = 0; i < 4; i++)
    begin
      w(0, 0, 1, 0, 0, i[1:0], 0, 0);
      chk(ev, {3'b001, lanes[i]});
    end
    w(0, 0, 1, 0, 1, 0, 0, 0);
    chk(ev, 7'h3F);
    w(0, 0, 0, 0, 1, 2'h3, 0, 0);
    chk(ev, 7'h0F);
    tx_port_select = 5'h05;
    repeat (8) @(negedge core_clk);
    chk(selected_port_space_flag_oe, 0);
    tx_port_select = 1;
    datapath_reset = 1;
    repeat (8) @(negedge core_clk);
    chk(selected_port_space_flag_oe, 0);
    datapath_reset = 0;
    w(1, 0, 0, 0, 0, 0, 0, 0);
    chk(selected_port_space_flag_oe, 0);
  endtask
  task automatic t_pkt_l3();
    go(MODE_PKT_L3, WIDTH_32);
    w(1, 0, 0, 1, 0, 0, 32'h3, 5'h0A);
    chk(selected_port_space_flag_oe, 1);
    chk({tx_target_valid, tx_target_port}, 6'h23);
    chk(rx_transfer_port, 5'h1F);
    w(0, 0, 0, 1, 0, 0, 32'h2, 0);
    chk(tx_target_port, 3);
  endtask
  task automatic t_misc();
    go(MODE_CELL_L3, WIDTH_32);
    port_has_room = 4'hF;
    w(0, 0, 0, 0, 0, 0, 0, 0);
    chk(selected_port_space_flag_o, 0);
    chk(selected_port_space_flag_oe, 1);
    go(MODE_PKT_L2, WIDTH_16);
    w(0, 0, 1, 0, 0, 2'h3, 0, 0);
    chk(ev, 7'h1F);
    go(MODE_PKT_L2, WIDTH_8);
    w(0, 0, 1, 0, 0, 2'h2, 0, 0);
    chk(ev, 7'h1F);
  endtask
  initial
  begin
    repeat (12) @(negedge core_clk);
    rst_n = 1;
    t_cell_l2();
    t_pkt_l2();
    t_pkt_l3();
    t_misc();
    end_of_test();
  end
endmodule
